// ==== rtl/io_port_config_decode.v ====
// Operation
// - Port E8h holds card mapping register index
// - EAh upper, EBh lower byte of card register
// - ECh config index, EDh accesses selected register
// - Read EEh enables A20, write disables
// - Read of EFh resets host processor
// - Write F0h clears coprocessor busy and request
// - Write F1h resets the numeric coprocessor
// - Write F4h selects slow processor clock
// - Write F5h selects fast processor clock
// - Write F9h blocks configuration register access
// - Write FBh allows configuration register access
// - Port 92h also drives A20 and reset
// - Misc setup MSB disables several port decodes
// - Clock detect bit follows bus oscillator while BUS_OSC_PRESENT_I is low, reads 0 otherwise
// - Management control bit reads interrupt pin live
// - Special-write registers writable only in SMM
// - ROM width bit read-only, strapped on the first clock after each reset release
`timescale 1ns/1ps
`default_nettype none
`include "io_port_config_decode_regs.vh"
module io_port_config_decode (
	input  wire        CLK_I,
	input  wire        RST_I,
	input  wire [7:0]  IO_ADDR_I,
	input  wire [7:0]  IO_WDATA_I,
	input  wire        IO_RD_I,
	input  wire        IO_WR_I,
	input  wire        SMM_ACTIVE_I,
	input  wire        ROM_WIDTH_STRAP_I,
	input  wire        BUS_OSC_PRESENT_I,
	input  wire        BUS_OSCILLATOR_INPUT_I,
	input  wire        MGMT_INTERRUPT_PIN_N_I,
	input  wire        COPRO_BUSY_SET_I,
	input  wire        COPRO_REQUEST_SET_I,
	output reg  [7:0]  IO_RDATA_O,
	output wire        IO_HIT_O,
	output reg         A20_GATE_O,
	output reg         CPU_RESET_O,
	output reg         COPRO_RESET_O,
	output reg         COPRO_BUSY_TO_HOST_O,
	output reg         COPRO_REQUEST_TO_HOST_O,
	output reg         SLOW_CLOCK_O,
	output reg         CONFIG_ENABLE_O
);

	reg  [7:0]  card_index_reg;
	reg  [15:0] card_map_reg [0:`CARD_MAP_COUNT-1];
	reg  [7:0]  config_index_reg;
	reg  [7:0]  clock_control_reg;
	reg  [7:0]  misc_setup_reg;
	reg  [7:0]  bus_control_one;
	reg  [7:0]  mgmt_interrupt_control;
	reg  [7:0]  rtc_base_low;
	reg  [7:0]  rtc_base_high;
	reg  [7:0]  keyboard_control;
	reg  [7:0]  trap2_addr_high;
	reg  [7:0]  trap2_addr_low;
	reg  [7:0]  trap1_addr_high;
	reg  [7:0]  trap1_addr_low;
	reg         rom_width_bit;
	reg         strap_taken_reg;
	reg         sys_reset_bit_reg;
	reg  [3:0]  cpu_reset_cnt_reg;
	reg  [3:0]  copro_reset_cnt_reg;
	reg  [7:0]  cfg_rdata;

	wire        decode_off;
	wire        cfg_write;
	wire        smm_ok;
	wire [3:0]  card_sel;
	wire        sys_ctl_wr;
	wire        busy_clr_wr;
	wire        copro_rst_wr;
	wire        cpu_rst_rd;

	function is_port;
		input [7:0] addr;
		input [7:0] port;
		begin
			is_port = (addr == port);
		end
	endfunction

	function gated_port;
		input [7:0] addr;
		input [7:0] port;
		input       off;
		begin
			gated_port = (addr == port) && !off;
		end
	endfunction

	assign decode_off = misc_setup_reg[`MISC_DECODE_OFF_BIT];
	assign card_sel   = card_index_reg[3:0];
	assign cfg_write  = IO_WR_I && is_port(IO_ADDR_I, `PORT_CFG_DATA) && CONFIG_ENABLE_O;
	assign smm_ok     = SMM_ACTIVE_I;
	assign sys_ctl_wr   = IO_WR_I && is_port(IO_ADDR_I, `PORT_SYS_CONTROL);
	assign busy_clr_wr  = IO_WR_I && is_port(IO_ADDR_I, `PORT_COPRO_BUSY_CLR);
	assign copro_rst_wr = IO_WR_I && is_port(IO_ADDR_I, `PORT_COPRO_RESET);
	assign cpu_rst_rd   = IO_RD_I && gated_port(IO_ADDR_I, `PORT_CPU_RESET, decode_off);

	assign IO_HIT_O = is_port(IO_ADDR_I, `PORT_CARD_INDEX)
		|| is_port(IO_ADDR_I, `PORT_CARD_UPPER)
		|| is_port(IO_ADDR_I, `PORT_CARD_LOWER)
		|| is_port(IO_ADDR_I, `PORT_CFG_INDEX)
		|| is_port(IO_ADDR_I, `PORT_CFG_DATA)
		|| is_port(IO_ADDR_I, `PORT_COPRO_BUSY_CLR)
		|| is_port(IO_ADDR_I, `PORT_COPRO_RESET)
		|| is_port(IO_ADDR_I, `PORT_SYS_CONTROL)
		|| gated_port(IO_ADDR_I, `PORT_A20_GATE, decode_off)
		|| gated_port(IO_ADDR_I, `PORT_CPU_RESET, decode_off)
		|| gated_port(IO_ADDR_I, `PORT_SLOW_CLOCK, decode_off)
		|| gated_port(IO_ADDR_I, `PORT_FAST_CLOCK, decode_off)
		|| gated_port(IO_ADDR_I, `PORT_CFG_LOCK, decode_off)
		|| gated_port(IO_ADDR_I, `PORT_CFG_UNLOCK, decode_off);

	// Configuration read mux
	always @*
	begin
		cfg_rdata = 8'h00;
		case (config_index_reg)
			`CFG_CLOCK_CONTROL:
			begin
				cfg_rdata = clock_control_reg;
				cfg_rdata[`CLOCK_CONTROL_REG_DETECT_BIT] = BUS_OSC_PRESENT_I ? 1'b0
					: BUS_OSCILLATOR_INPUT_I;
			end
			`CFG_MISC_SETUP:       cfg_rdata = misc_setup_reg;
			`CFG_BUS_CONTROL_ONE:
			begin
				cfg_rdata = bus_control_one;
				cfg_rdata[`BUS1_ROM_WIDTH_BIT] = rom_width_bit;
			end
			`CFG_MGMT_INT_CONTROL:
			begin
				cfg_rdata = mgmt_interrupt_control;
				cfg_rdata[`MGMT_PIN_BIT] = MGMT_INTERRUPT_PIN_N_I;
			end
			`CFG_RTC_BASE_LOW:     cfg_rdata = rtc_base_low;
			`CFG_RTC_BASE_HIGH:    cfg_rdata = rtc_base_high;
			`CFG_KEYBOARD_CONTROL: cfg_rdata = keyboard_control;
			`CFG_TRAP2_HIGH:       cfg_rdata = trap2_addr_high;
			`CFG_TRAP2_LOW:        cfg_rdata = trap2_addr_low;
			`CFG_TRAP1_HIGH:       cfg_rdata = trap1_addr_high;
			`CFG_TRAP1_LOW:        cfg_rdata = trap1_addr_low;
			default:               cfg_rdata = 8'h00;
		endcase
	end

	// Read data register
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			IO_RDATA_O <= 8'h00;
		else if (IO_RD_I)
		begin
			case (IO_ADDR_I)
				`PORT_CARD_INDEX:  IO_RDATA_O <= card_index_reg;
				`PORT_CARD_UPPER:  IO_RDATA_O <= card_map_reg[card_sel][15:8];
				`PORT_CARD_LOWER:  IO_RDATA_O <= card_map_reg[card_sel][7:0];
				`PORT_CFG_INDEX:   IO_RDATA_O <= config_index_reg;
				`PORT_CFG_DATA:    IO_RDATA_O <= CONFIG_ENABLE_O ? cfg_rdata : 8'hFF;
				`PORT_SYS_CONTROL: IO_RDATA_O <= {6'h00, A20_GATE_O, sys_reset_bit_reg};
				default:           IO_RDATA_O <= 8'hFF;
			endcase
		end
	end

	// Index registers and card mapping storage
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			card_index_reg   <= 8'h00;
			config_index_reg <= 8'h00;
		end
		else if (IO_WR_I)
		begin
			if (is_port(IO_ADDR_I, `PORT_CARD_INDEX))
				card_index_reg <= IO_WDATA_I;
			if (is_port(IO_ADDR_I, `PORT_CFG_INDEX))
				config_index_reg <= IO_WDATA_I;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `CARD_MAP_COUNT; gi = gi + 1)
		begin : g_card
			localparam [3:0] slot_id = gi;
			always @(posedge CLK_I or posedge RST_I)
			begin
				if (RST_I)
					card_map_reg[gi] <= `RST_CARD_MAP;
				else if (IO_WR_I && card_sel == slot_id)
				begin
					if (is_port(IO_ADDR_I, `PORT_CARD_UPPER))
						card_map_reg[gi][15:8] <= IO_WDATA_I;
					if (is_port(IO_ADDR_I, `PORT_CARD_LOWER))
						card_map_reg[gi][7:0] <= IO_WDATA_I;
				end
			end
		end
	endgenerate

	// Configuration registers
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			clock_control_reg      <= `RST_CLOCK_CONTROL;
			misc_setup_reg         <= `RST_MISC_SETUP;
			bus_control_one        <= `RST_BUS_CONTROL_ONE;
			mgmt_interrupt_control <= `RST_MGMT_INT_CONTROL;
			rtc_base_low           <= `RST_RTC_BASE_LOW;
			rtc_base_high          <= `RST_RTC_BASE_HIGH;
			keyboard_control       <= `RST_KEYBOARD_CONTROL;
			trap2_addr_high        <= `RST_TRAP;
			trap2_addr_low         <= `RST_TRAP;
			trap1_addr_high        <= `RST_TRAP;
			trap1_addr_low         <= `RST_TRAP;
		end
		else if (cfg_write)
		begin
			case (config_index_reg)
				`CFG_CLOCK_CONTROL:    clock_control_reg <= IO_WDATA_I;
				`CFG_MISC_SETUP:       misc_setup_reg <= IO_WDATA_I;
				`CFG_BUS_CONTROL_ONE:  bus_control_one <= IO_WDATA_I;
				`CFG_MGMT_INT_CONTROL:
					if (smm_ok) mgmt_interrupt_control <= IO_WDATA_I;
				`CFG_RTC_BASE_LOW:     rtc_base_low <= IO_WDATA_I;
				`CFG_RTC_BASE_HIGH:    rtc_base_high <= IO_WDATA_I;
				`CFG_KEYBOARD_CONTROL: keyboard_control <= IO_WDATA_I;
				`CFG_TRAP2_HIGH:       if (smm_ok) trap2_addr_high <= IO_WDATA_I;
				`CFG_TRAP2_LOW:        if (smm_ok) trap2_addr_low <= IO_WDATA_I;
				`CFG_TRAP1_HIGH:       if (smm_ok) trap1_addr_high <= IO_WDATA_I;
				`CFG_TRAP1_LOW:        if (smm_ok) trap1_addr_low <= IO_WDATA_I;
				default:               clock_control_reg <= clock_control_reg;
			endcase
		end
	end

	// Strap capture after reset release
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			rom_width_bit   <= 1'b0;
			strap_taken_reg <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			rom_width_bit   <= ROM_WIDTH_STRAP_I;
			strap_taken_reg <= 1'b1;
		end
	end

	// Single-port actions
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			A20_GATE_O        <= 1'b0;
			SLOW_CLOCK_O      <= 1'b0;
			CONFIG_ENABLE_O   <= 1'b1;
			sys_reset_bit_reg <= 1'b0;
		end
		else
		begin
			if (IO_RD_I && gated_port(IO_ADDR_I, `PORT_A20_GATE, decode_off))
				A20_GATE_O <= 1'b1;
			else if (IO_WR_I && gated_port(IO_ADDR_I, `PORT_A20_GATE, decode_off))
				A20_GATE_O <= 1'b0;
			else if (sys_ctl_wr)
				A20_GATE_O <= IO_WDATA_I[`SYSCTL_A20_BIT];
			if (sys_ctl_wr)
				sys_reset_bit_reg <= IO_WDATA_I[`SYSCTL_RESET_BIT];
			if (IO_WR_I && gated_port(IO_ADDR_I, `PORT_SLOW_CLOCK, decode_off))
				SLOW_CLOCK_O <= 1'b1;
			else if (IO_WR_I && gated_port(IO_ADDR_I, `PORT_FAST_CLOCK, decode_off))
				SLOW_CLOCK_O <= 1'b0;
			if (IO_WR_I && gated_port(IO_ADDR_I, `PORT_CFG_LOCK, decode_off))
				CONFIG_ENABLE_O <= 1'b0;
			else if (IO_WR_I && gated_port(IO_ADDR_I, `PORT_CFG_UNLOCK, decode_off))
				CONFIG_ENABLE_O <= 1'b1;
		end
	end

	// Processor and coprocessor reset pulses
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			cpu_reset_cnt_reg   <= 4'h0;
			copro_reset_cnt_reg <= 4'h0;
			CPU_RESET_O         <= 1'b0;
			COPRO_RESET_O       <= 1'b0;
		end
		else
		begin
			if (cpu_rst_rd
				|| (sys_ctl_wr && IO_WDATA_I[`SYSCTL_RESET_BIT]
				&& !sys_reset_bit_reg))
				cpu_reset_cnt_reg <= `CPU_RESET_CYCLES;
			else if (cpu_reset_cnt_reg != 4'h0)
				cpu_reset_cnt_reg <= cpu_reset_cnt_reg - 4'h1;
			if (copro_rst_wr)
				copro_reset_cnt_reg <= `COPRO_RESET_CYCLES;
			else if (copro_reset_cnt_reg != 4'h0)
				copro_reset_cnt_reg <= copro_reset_cnt_reg - 4'h1;
			CPU_RESET_O   <= (cpu_reset_cnt_reg != 4'h0);
			COPRO_RESET_O <= (copro_reset_cnt_reg != 4'h0);
		end
	end

	// Coprocessor status toward host; a set in the clear cycle wins
	always @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			COPRO_BUSY_TO_HOST_O    <= 1'b0;
			COPRO_REQUEST_TO_HOST_O <= 1'b0;
		end
		else
		begin
			if (COPRO_BUSY_SET_I)
				COPRO_BUSY_TO_HOST_O <= 1'b1;
			else if (busy_clr_wr)
				COPRO_BUSY_TO_HOST_O <= 1'b0;
			if (COPRO_REQUEST_SET_I)
				COPRO_REQUEST_TO_HOST_O <= 1'b1;
			else if (busy_clr_wr)
				COPRO_REQUEST_TO_HOST_O <= 1'b0;
		end
	end

endmodule // io_port_config_decode
`default_nettype wire

// ==== include/io_port_config_decode_regs.vh ====
`ifndef IO_PORT_CONFIG_DECODE_REGS_VH
`define IO_PORT_CONFIG_DECODE_REGS_VH
// Dedicated I/O port addresses
`define PORT_CARD_INDEX      8'hE8
`define PORT_CARD_UPPER      8'hEA
`define PORT_CARD_LOWER      8'hEB
`define PORT_CFG_INDEX       8'hEC
`define PORT_CFG_DATA        8'hED
`define PORT_A20_GATE        8'hEE
`define PORT_CPU_RESET       8'hEF
`define PORT_COPRO_BUSY_CLR  8'hF0
`define PORT_COPRO_RESET     8'hF1
`define PORT_SLOW_CLOCK      8'hF4
`define PORT_FAST_CLOCK      8'hF5
`define PORT_CFG_LOCK        8'hF9
`define PORT_CFG_UNLOCK      8'hFB
`define PORT_SYS_CONTROL     8'h92
// System control port bits
`define SYSCTL_RESET_BIT     0
`define SYSCTL_A20_BIT       1
// Configuration register indices
`define CFG_CLOCK_CONTROL    8'h07
`define CFG_MISC_SETUP       8'h14
`define CFG_BUS_CONTROL_ONE  8'h16
`define CFG_MGMT_INT_CONTROL 8'h18
`define CFG_RTC_BASE_LOW     8'h1B
`define CFG_RTC_BASE_HIGH    8'h1C
`define CFG_KEYBOARD_CONTROL 8'h1D
`define CFG_TRAP2_HIGH       8'h84
`define CFG_TRAP2_LOW        8'h85
`define CFG_TRAP1_HIGH       8'h86
`define CFG_TRAP1_LOW        8'h87
// Field positions
`define CLOCK_CONTROL_REG_DETECT_BIT    2
`define MISC_DECODE_OFF_BIT  7
`define BUS1_ROM_WIDTH_BIT   7
`define MGMT_PIN_BIT         3
// Reset values
`define RST_CLOCK_CONTROL    8'h20
`define RST_MISC_SETUP       8'h11
`define RST_BUS_CONTROL_ONE  8'h40
`define RST_MGMT_INT_CONTROL 8'h20
`define RST_RTC_BASE_LOW     8'h70
`define RST_RTC_BASE_HIGH    8'h20
`define RST_KEYBOARD_CONTROL 8'h93
`define RST_TRAP             8'h00
`define RST_CARD_MAP         16'h0000
// Sizes and timing counts
`define CARD_MAP_COUNT       16
`define CPU_RESET_CYCLES     4'h8
`define COPRO_RESET_CYCLES   4'h8
`endif

// ==== verification/io_port_config_decode_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "io_port_config_decode_regs.vh"
module io_port_config_decode_assertions (
	input wire logic       CLK_I,
	input wire logic       RST_I,
	input wire logic [7:0] IO_ADDR_I,
	input wire logic [7:0] IO_WDATA_I,
	input wire logic       IO_RD_I,
	input wire logic       IO_WR_I,
	input wire logic       COPRO_BUSY_SET_I,
	input wire logic       COPRO_REQUEST_SET_I,
	input wire logic [7:0] IO_RDATA_O,
	input wire logic       IO_HIT_O,
	input wire logic       A20_GATE_O,
	input wire logic       CPU_RESET_O,
	input wire logic       COPRO_RESET_O,
	input wire logic       COPRO_BUSY_TO_HOST_O,
	input wire logic       COPRO_REQUEST_TO_HOST_O,
	input wire logic       SLOW_CLOCK_O,
	input wire logic       CONFIG_ENABLE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	wire rdh = IO_RD_I && IO_HIT_O;
	wire wrh = IO_WR_I && IO_HIT_O;
	AST_A20_ON: assert property (rdh && IO_ADDR_I == `PORT_A20_GATE |=> A20_GATE_O)
		else $error("a20 not set by read");
	AST_A20_OFF: assert property (wrh && IO_ADDR_I == `PORT_A20_GATE |=> !A20_GATE_O)
		else $error("a20 not cleared by write");
	AST_CPU_RST: assert property (rdh && IO_ADDR_I == `PORT_CPU_RESET |-> ##2 CPU_RESET_O[*8])
		else $error("cpu reset pulse wrong");
	AST_BUSY_CLR: assert property (wrh && IO_ADDR_I == `PORT_COPRO_BUSY_CLR
		&& !COPRO_BUSY_SET_I && !COPRO_REQUEST_SET_I
		|=> !COPRO_BUSY_TO_HOST_O && !COPRO_REQUEST_TO_HOST_O)
		else $error("busy or request not cleared");
	AST_NPX_RST: assert property (wrh && IO_ADDR_I == `PORT_COPRO_RESET |-> ##2 COPRO_RESET_O[*8])
		else $error("coprocessor reset pulse wrong");
	AST_SLOW: assert property (wrh && IO_ADDR_I == `PORT_SLOW_CLOCK |=> SLOW_CLOCK_O)
		else $error("slow clock not selected");
	AST_FAST: assert property (wrh && IO_ADDR_I == `PORT_FAST_CLOCK |=> !SLOW_CLOCK_O)
		else $error("fast clock not selected");
	AST_LOCK: assert property (wrh && IO_ADDR_I == `PORT_CFG_LOCK |=> !CONFIG_ENABLE_O)
		else $error("config not locked");
	AST_UNLOCK: assert property (wrh && IO_ADDR_I == `PORT_CFG_UNLOCK |=> CONFIG_ENABLE_O)
		else $error("config not unlocked");
	AST_SYS_A20: assert property (IO_WR_I && IO_ADDR_I == `PORT_SYS_CONTROL
		|=> A20_GATE_O == $past(IO_WDATA_I[1]))
		else $error("system port a20 wrong");
	AST_LOCK_RD: assert property (IO_RD_I && IO_ADDR_I == `PORT_CFG_DATA && !CONFIG_ENABLE_O
		|=> IO_RDATA_O == 8'hFF)
		else $error("locked data read not FF");
	COV_RST: cover property (CPU_RESET_O && COPRO_RESET_O == 1'h0);
	COV_LOCK: cover property (!CONFIG_ENABLE_O ##1 CONFIG_ENABLE_O);
	COV_SLOW: cover property (SLOW_CLOCK_O && A20_GATE_O);
endmodule // io_port_config_decode_assertions
bind io_port_config_decode io_port_config_decode_assertions chk (.CLK_I(CLK_I), .RST_I(RST_I),
	.IO_ADDR_I(IO_ADDR_I), .IO_WDATA_I(IO_WDATA_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I),
	.COPRO_BUSY_SET_I(COPRO_BUSY_SET_I), .COPRO_REQUEST_SET_I(COPRO_REQUEST_SET_I),
	.IO_RDATA_O(IO_RDATA_O), .IO_HIT_O(IO_HIT_O), .A20_GATE_O(A20_GATE_O),
	.CPU_RESET_O(CPU_RESET_O), .COPRO_RESET_O(COPRO_RESET_O),
	.COPRO_BUSY_TO_HOST_O(COPRO_BUSY_TO_HOST_O), .COPRO_REQUEST_TO_HOST_O(COPRO_REQUEST_TO_HOST_O),
	.SLOW_CLOCK_O(SLOW_CLOCK_O), .CONFIG_ENABLE_O(CONFIG_ENABLE_O));
`default_nettype wire

// ==== verification/host_io_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output var  logic [7:0] addr,
	output var  logic [7:0] wdata,
	output var  logic       rd,
	output var  logic       wr
);
	initial
	begin
		addr = 8'h00;
		wdata = 8'h00;
		rd = 1'h0;
		wr = 1'h0;
	end
	// Parks an address on the bus with both strobes low
	task idle_addr(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
	endtask
	// Released lines show the inverse of the last value
	task io_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task io_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		addr <= ~a;
		#1 d = rdata;
	endtask
endmodule // host_io_model
`default_nettype wire

// ==== verification/io_port_config_decode_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "io_port_config_decode_regs.vh"
module io_port_config_decode_test;
	logic CLK_I = 1'h0;
	logic RST_I, smm, strap, osc_on, osc_in, pin_n, bset, rset;
	logic [7:0] addr, wdata, rdata, v, d;
	logic rd, wr, hit, a20, cpu_rst, npx_rst, busy, req, slow, cfg_en;
	logic [15:0] card [`CARD_MAP_COUNT];
	logic [7:0] dflt [7] = '{8'h07, 8'h14, 8'h16, 8'h18, 8'h1B, 8'h1C, 8'h1D};
	int err_total = 0, comparisons = 0, i, n;
	always #10 CLK_I = ~CLK_I;
	host_io_model host (.clk(CLK_I), .rdata(rdata), .addr(addr), .wdata(wdata), .rd(rd), .wr(wr));
	io_port_config_decode dut (.CLK_I(CLK_I), .RST_I(RST_I), .IO_ADDR_I(addr), .IO_WDATA_I(wdata),
		.IO_RD_I(rd), .IO_WR_I(wr), .SMM_ACTIVE_I(smm), .ROM_WIDTH_STRAP_I(strap),
		.BUS_OSC_PRESENT_I(osc_on), .BUS_OSCILLATOR_INPUT_I(osc_in), .MGMT_INTERRUPT_PIN_N_I(pin_n),
		.COPRO_BUSY_SET_I(bset), .COPRO_REQUEST_SET_I(rset), .IO_RDATA_O(rdata), .IO_HIT_O(hit),
		.A20_GATE_O(a20), .CPU_RESET_O(cpu_rst), .COPRO_RESET_O(npx_rst),
		.COPRO_BUSY_TO_HOST_O(busy), .COPRO_REQUEST_TO_HOST_O(req), .SLOW_CLOCK_O(slow),
		.CONFIG_ENABLE_O(cfg_en));
	function automatic logic [7:0] cfg_exp(input logic [7:0] idx);
		case (idx)
			8'h07: cfg_exp = osc_on ? 8'h20 : {5'h04, osc_in, 2'h0};
			8'h14: cfg_exp = 8'h11;
			8'h16: cfg_exp = {strap, 7'h40};
			8'h18: cfg_exp = {4'h2, pin_n, 3'h0};
			8'h1B: cfg_exp = 8'h70;
			8'h1C: cfg_exp = 8'h20;
			default: cfg_exp = 8'h93;
		endcase
	endfunction
	task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task cfg_wr(input logic [7:0] idx, input logic [7:0] val);
		host.io_wr(`PORT_CFG_INDEX, idx);
		host.io_wr(`PORT_CFG_DATA, val);
	endtask
	task cfg_rd(input logic [7:0] idx, output logic [7:0] val);
		host.io_wr(`PORT_CFG_INDEX, idx);
		host.io_rd(`PORT_CFG_DATA, val);
	endtask
	task pulse_len(input logic copro, output int cnt);
		cnt = 0;
		repeat (12)
		begin
			@(posedge CLK_I);
			#1 if ((copro ? npx_rst : cpu_rst) === 1'h1) cnt++;
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		n = $urandom(69365);
		RST_I = 1'h1;
		{smm, osc_on, osc_in, pin_n, bset, rset} = 6'h18;
		strap = 1'($urandom);
		repeat (3) @(posedge CLK_I);
		RST_I <= 1'h0;
		for (i = 0; i < 7; i++)
		begin
			cfg_rd(dflt[i], v);
			check(v, cfg_exp(dflt[i]), "default");
		end
		for (i = 0; i < 4; i++)
		begin
			@(posedge CLK_I);
			osc_on <= 1'h0;
			osc_in <= 1'($urandom);
			pin_n <= 1'($urandom);
			cfg_rd(`CFG_CLOCK_CONTROL, v);
			check(v, cfg_exp(`CFG_CLOCK_CONTROL), "clock detect");
			cfg_rd(`CFG_MGMT_INT_CONTROL, v);
			check(v, cfg_exp(`CFG_MGMT_INT_CONTROL), "mgmt pin");
		end
		cfg_wr(`CFG_BUS_CONTROL_ONE, {~strap, 7'h40});
		cfg_rd(`CFG_BUS_CONTROL_ONE, v);
		check({7'h00, v[7]}, {7'h00, strap}, "rom width");
		cfg_wr(`CFG_TRAP1_LOW, 8'h5A);
		cfg_rd(`CFG_TRAP1_LOW, v);
		check(v, 8'h00, "trap write outside smm");
		@(posedge CLK_I);
		smm <= 1'h1;
		for (i = 0; i < 4; i++)
		begin
			d = $urandom;
			cfg_wr(`CFG_TRAP2_HIGH + 8'(i), d);
			cfg_rd(`CFG_TRAP2_HIGH + 8'(i), v);
			check(v, d, "trap in smm");
		end
		d = $urandom;
		cfg_wr(`CFG_RTC_BASE_LOW, d);
		cfg_rd(`CFG_RTC_BASE_LOW, v);
		check(v, d, "config data");
		host.io_wr(`PORT_CFG_LOCK, 8'h00);
		cfg_wr(`CFG_RTC_BASE_LOW, ~d);
		host.io_rd(`PORT_CFG_DATA, v);
		check(v, 8'hFF, "locked read");
		host.io_wr(`PORT_CFG_UNLOCK, 8'h00);
		cfg_rd(`CFG_RTC_BASE_LOW, v);
		check(v, d, "locked write ignored");
		for (i = 0; i < `CARD_MAP_COUNT; i++)
		begin
			card[i] = $urandom;
			host.io_wr(`PORT_CARD_INDEX, 8'(i));
			host.io_wr(`PORT_CARD_UPPER, card[i][15:8]);
			host.io_wr(`PORT_CARD_LOWER, card[i][7:0]);
		end
		for (i = `CARD_MAP_COUNT - 1; i >= 0; i--)
		begin
			host.io_wr(`PORT_CARD_INDEX, 8'(i));
			host.io_rd(`PORT_CARD_UPPER, v);
			check(v, card[i][15:8], "card upper");
			host.io_rd(`PORT_CARD_LOWER, v);
			check(v, card[i][7:0], "card lower");
		end
		host.io_rd(`PORT_A20_GATE, v);
		check({7'h00, a20}, 8'h01, "a20 on");
		host.io_wr(`PORT_A20_GATE, 8'h00);
		#1 check({7'h00, a20}, 8'h00, "a20 off");
		host.io_wr(`PORT_SYS_CONTROL, 8'h02);
		#1 check({7'h00, a20}, 8'h01, "system a20");
		host.io_rd(`PORT_CPU_RESET, v);
		pulse_len(1'h0, n);
		check(8'(n), {4'h0, `CPU_RESET_CYCLES}, "cpu reset");
		host.io_wr(`PORT_SYS_CONTROL, 8'h03);
		pulse_len(1'h0, n);
		check(8'(n), {4'h0, `CPU_RESET_CYCLES}, "system cpu reset");
		host.io_wr(`PORT_COPRO_RESET, 8'h00);
		pulse_len(1'h1, n);
		check(8'(n), {4'h0, `COPRO_RESET_CYCLES}, "copro reset");
		@(posedge CLK_I);
		{bset, rset} <= 2'h3;
		@(posedge CLK_I);
		{bset, rset} <= 2'h0;
		#1 check({6'h00, busy, req}, 8'h03, "busy set");
		host.io_wr(`PORT_COPRO_BUSY_CLR, 8'h00);
		#1 check({6'h00, busy, req}, 8'h00, "busy clear");
		cfg_rd(`CFG_MISC_SETUP, v);
		cfg_wr(`CFG_MISC_SETUP, v | 8'h80);
		host.io_wr(`PORT_SLOW_CLOCK, 8'h00);
		host.io_wr(`PORT_A20_GATE, 8'h00);
		host.io_wr(`PORT_CFG_LOCK, 8'h00);
		#1 check({5'h00, slow, a20, cfg_en}, 8'h03, "decodes off");
		host.idle_addr(`PORT_CPU_RESET);
		#1 check({7'h00, hit}, 8'h00, "gated decode hit");
		cfg_wr(`CFG_MISC_SETUP, v);
		host.idle_addr(`PORT_CPU_RESET);
		#1 check({7'h00, hit}, 8'h01, "restored decode hit");
		host.io_wr(`PORT_SLOW_CLOCK, 8'h00);
		#1 check({7'h00, slow}, 8'h01, "slow clock");
		host.io_wr(`PORT_FAST_CLOCK, 8'h00);
		#1 check({7'h00, slow}, 8'h00, "fast clock");
		tally_and_finish();
	end
endmodule // io_port_config_decode_test
`default_nettype wire
